/* rtl/uat_pkg.sv */
// Purpose: constants for the usb2 front-end test override register block
// Assumes: axi4-lite slave with 32-bit data, one register word
// Notes:   field positions and the fs_oe_n, txv, txd and boost reset values live here
package uat_pkg;
   localparam logic [11:0] UAT_OFF_TEST     = 12'h0c4;
   localparam int          UAT_AW           = 12;
   localparam int          UAT_FS_OE_N_BIT  = 22;
   localparam int          UAT_FS_POS_BIT   = 21;
   localparam int          UAT_FS_NEG_BIT   = 20;
   localparam int          UAT_FS_RX_BIT    = 19;
   localparam int          UAT_TXV_LSB      = 14;
   localparam int          UAT_TXD_LSB      = 12;
   localparam int          UAT_CS_BIT       = 11;
   localparam int          UAT_BOOST_LSB    = 8;
   localparam int          UAT_RPU_DP_BIT   = 7;
   localparam int          UAT_RPU_DM_BIT   = 6;
   localparam int          UAT_RPD_DP_BIT   = 5;
   localparam int          UAT_RPD_DM_BIT   = 4;
   localparam int          UAT_ACTIVE_BIT   = 1;
   localparam logic        UAT_FS_OE_N_RST  = 1'h0;
   localparam logic [1:0]  UAT_TXV_RST      = 2'h0;
   localparam logic [1:0]  UAT_TXV_BAD      = 2'h2;
   localparam logic [1:0]  UAT_TXD_RST      = 2'h0;
   localparam logic [2:0]  UAT_BOOST_RST    = 3'h0;
   localparam logic [1:0]  UAT_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  UAT_RESP_SLVERR  = 2'h2;
   localparam logic [1:0]  UAT_RESP_DECERR  = 2'h3;

   typedef enum logic [1:0] {
      UAT_W_IDLE = 2'b01,
      UAT_W_RESP = 2'b10
   } uat_wst_e;

   typedef enum logic [1:0] {
      UAT_R_IDLE = 2'b01,
      UAT_R_DATA = 2'b10
   } uat_rst_e;
endpackage

/* rtl/uat_test_override.sv */
// Purpose: usb2 analog front-end test override register on axi4-lite
// Assumes: front-end signals synchronous to aclk; nv default already loaded
// Notes:   single register word; other addresses answer decerr
//
// How it works
// R1: fs/ls driver enable is active low; one tri-states the driver.
// R2: fs/ls positive data bit drives the dp line output.
// R3: fs/ls negative data bit drives the dm line output.
// R4: receiver output bit is read-only and follows the live receiver.
// R5: valid mask 00 none, 01 lsb, 11 both; a write of 10 is refused with slverr.
// R6: two-bit hs transmit data is sent lsb first.
// R7: current source bit powers driver; forced on while in high-speed mode.
// R8: three-bit boost selects drive current level per the documented table.
// R9: boost is the only field that protected resets revert; the others survive them.
// R10: boost default from eeprom, else otp, else 000b.
// R11: usb or lite reset reloads boost from eeprom image, or clears it.
// R12: dp pull-up bit switches the 1.5k dp termination.
// R13: second pull-up bit switches the 1.5k pull-up termination.
// R14: dp pull-down bit switches the 15k dp termination.
// R15: dm pull-down bit switches the 15k dm termination.
// R16: driver active bit selects low-power or active transmit mode.
// R17: reserved bits read zero; writable fields read back last write, except the cs bit, which reads cs_en or hs_mode, and boost after a protected reset.
`timescale 1ns/1ps
module uat_test_override
   import uat_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [UAT_AW-1:0]   s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output      logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output      logic                s_axi_wready,
   output      logic [1:0]          s_axi_bresp,
   output      logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [UAT_AW-1:0]   s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output      logic                s_axi_arready,
   output      logic [31:0]         s_axi_rdata,
   output      logic [1:0]          s_axi_rresp,
   output      logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                fs_ls_diff_rx_out,
   input  wire logic                hs_mode,
   input  wire logic                usb_reset,
   input  wire logic                lite_reset,
   input  wire logic                eeprom_present,
   input  wire logic                otp_programmed,
   input  wire logic [2:0]          nv_drive_current_default,
   output      logic                fs_ls_driver_enable_n,
   output      logic                fs_ls_dp_out,
   output      logic                fs_ls_dm_out,
   output      logic [1:0]          frontend_hs_tx_valid_bus,
   output      logic                hs_tx_serial,
   output      logic                hs_current_source_on,
   output      logic [2:0]          hs_drive_current_sel,
   output      logic                dp_pullup_on,
   output      logic                dm_pullup_on,
   output      logic                dp_pulldown_on,
   output      logic                dm_pulldown_on,
   output      logic                hs_driver_active
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      uat_wst_e              wst;
      logic                  aw_got;
      logic                  w_got;
      logic [UAT_AW-1:0]     awaddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic [1:0]            bresp;
      uat_rst_e              rst;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic                  fs_oe_n;
      logic                  fs_pos;
      logic                  fs_neg;
      logic                  rx_sync;
      logic [1:0]            txv;
      logic [1:0]            txd;
      logic                  ser_phase;
      logic                  ser_bit;
      logic                  cs_en;
      logic                  cs_out;
      logic [2:0]            boost;
      logic [2:0]            eeprom_image;
      logic                  boot_done;
      logic                  rpu_dp;
      logic                  rpu_dm;
      logic                  rpd_dp;
      logic                  rpd_dm;
      logic                  active;
      logic [1:0]            txv_out;
   } uat_state_s;

   uat_state_s st_q;
   uat_state_s st_d;
   logic [31:0] reg_view;

   ////////////////////////////////////////////////////////////////////////////
   // readback assembly: reserved positions stay zero
   always_comb begin
      reg_view                   = 32'h0;                                    // R17
      reg_view[UAT_FS_OE_N_BIT]  = st_q.fs_oe_n;
      reg_view[UAT_FS_POS_BIT]   = st_q.fs_pos;
      reg_view[UAT_FS_NEG_BIT]   = st_q.fs_neg;
      reg_view[UAT_FS_RX_BIT]    = st_q.rx_sync;                             // R4
      reg_view[UAT_TXV_LSB +: 2] = st_q.txv;
      reg_view[UAT_TXD_LSB +: 2] = st_q.txd;
      reg_view[UAT_CS_BIT]       = st_q.cs_out;
      reg_view[UAT_BOOST_LSB +: 3] = st_q.boost;
      reg_view[UAT_RPU_DP_BIT]   = st_q.rpu_dp;
      reg_view[UAT_RPU_DM_BIT]   = st_q.rpu_dm;
      reg_view[UAT_RPD_DP_BIT]   = st_q.rpd_dp;
      reg_view[UAT_RPD_DM_BIT]   = st_q.rpd_dm;
      reg_view[UAT_ACTIVE_BIT]   = st_q.active;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0] wv;
      logic        do_write;
      logic [1:0]  new_txv;
      wv       = st_q.wdata;
      do_write = 1'b0;
      new_txv  = st_q.wdata[UAT_TXV_LSB +: 2];
      st_d     = st_q;

      // write channel: address and data taken in either order
      case (st_q.wst)
         UAT_W_IDLE: begin
            if (s_axi_awvalid && !st_q.aw_got) begin
               st_d.aw_got = 1'b1;
               st_d.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_q.w_got) begin
               st_d.w_got = 1'b1;
               st_d.wdata = s_axi_wdata;
               st_d.wstrb = s_axi_wstrb;
            end
            if (st_q.aw_got && st_q.w_got) begin
               st_d.aw_got = 1'b0;
               st_d.w_got  = 1'b0;
               st_d.wst    = UAT_W_RESP;
               if (st_q.awaddr[UAT_AW-1:2] != UAT_OFF_TEST[UAT_AW-1:2]) begin
                  st_d.bresp = UAT_RESP_DECERR;
               end else if (st_q.wstrb[1] && new_txv == UAT_TXV_BAD) begin
                  st_d.bresp = UAT_RESP_SLVERR;                              // R5
               end else begin
                  st_d.bresp = UAT_RESP_OKAY;
                  do_write   = 1'b1;
               end
            end
         end
         UAT_W_RESP: begin
            if (s_axi_bready) begin
               st_d.wst = UAT_W_IDLE;
            end
         end
         default: begin
            st_d.wst = UAT_W_IDLE;
         end
      endcase

      if (do_write && st_q.wstrb[2]) begin
         st_d.fs_oe_n = wv[UAT_FS_OE_N_BIT];                                 // R1
         st_d.fs_pos  = wv[UAT_FS_POS_BIT];
         st_d.fs_neg  = wv[UAT_FS_NEG_BIT];
      end
      if (do_write && st_q.wstrb[1]) begin
         st_d.txv   = wv[UAT_TXV_LSB +: 2];
         st_d.txd   = wv[UAT_TXD_LSB +: 2];
         st_d.cs_en = wv[UAT_CS_BIT];
         st_d.boost = wv[UAT_BOOST_LSB +: 3];                                // R8
      end
      if (do_write && st_q.wstrb[0]) begin
         st_d.rpu_dp = wv[UAT_RPU_DP_BIT];
         st_d.rpu_dm = wv[UAT_RPU_DM_BIT];
         st_d.rpd_dp = wv[UAT_RPD_DP_BIT];
         st_d.rpd_dm = wv[UAT_RPD_DM_BIT];
         st_d.active = wv[UAT_ACTIVE_BIT];
      end

      // boost default: eeprom, else otp, else zero; latched once after reset
      if (!st_q.boot_done) begin
         st_d.boot_done = 1'b1;
         if (eeprom_present || otp_programmed) begin                         // R10
            st_d.boost = nv_drive_current_default;
         end else begin
            st_d.boost = UAT_BOOST_RST;
         end
         st_d.eeprom_image = eeprom_present ? nv_drive_current_default : UAT_BOOST_RST;
      end else if (usb_reset || lite_reset) begin
         // protected reset: only boost reverts, to eeprom image or zero, over any write
         st_d.boost = eeprom_present ? st_q.eeprom_image : UAT_BOOST_RST;    // R11
      end

      // read channel
      case (st_q.rst)
         UAT_R_IDLE: begin
            if (s_axi_arvalid) begin
               st_d.rst = UAT_R_DATA;
               if (s_axi_araddr[UAT_AW-1:2] == UAT_OFF_TEST[UAT_AW-1:2]) begin
                  st_d.rdata = reg_view;                                     // R17
                  st_d.rresp = UAT_RESP_OKAY;
               end else begin
                  st_d.rdata = 32'h0;
                  st_d.rresp = UAT_RESP_DECERR;
               end
            end
         end
         UAT_R_DATA: begin
            if (s_axi_rready) begin
               st_d.rst = UAT_R_IDLE;
            end
         end
         default: begin
            st_d.rst = UAT_R_IDLE;
         end
      endcase

      // live front-end status and derived line controls
      st_d.rx_sync = fs_ls_diff_rx_out;                                      // R4
      st_d.cs_out  = st_q.cs_en | hs_mode;                                   // R7
      st_d.txv_out = st_q.txv;                                               // R5
      // two-bit symbol shifted out lsb first, one bit per clock; a landed write with
      // wstrb[1] set restarts at the lsb so a new symbol never begins half-way through
      st_d.ser_phase = (do_write && st_q.wstrb[1]) ? 1'b0 : ~st_q.ser_phase;
      st_d.ser_bit   = st_q.ser_phase ? st_q.txd[1] : st_q.txd[0];           // R6
   end

   ////////////////////////////////////////////////////////////////////////////
   // aresetn is not a protected reset: boost reloads from the nv default, or zero without eeprom or otp, next edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q           <= '0;
         st_q.wst       <= UAT_W_IDLE;
         st_q.rst       <= UAT_R_IDLE;
         st_q.fs_oe_n   <= UAT_FS_OE_N_RST;
         st_q.txv       <= UAT_TXV_RST;
         st_q.txv_out   <= UAT_TXV_RST;
         st_q.txd       <= UAT_TXD_RST;
         st_q.boost     <= UAT_BOOST_RST;                                    // R9
         st_q.boot_done <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready            = (st_q.wst == UAT_W_IDLE) && !st_q.aw_got;
   assign s_axi_wready             = (st_q.wst == UAT_W_IDLE) && !st_q.w_got;
   assign s_axi_bvalid             = (st_q.wst == UAT_W_RESP);
   assign s_axi_bresp              = st_q.bresp;
   assign s_axi_arready            = (st_q.rst == UAT_R_IDLE);
   assign s_axi_rvalid             = (st_q.rst == UAT_R_DATA);
   assign s_axi_rdata              = st_q.rdata;
   assign s_axi_rresp              = st_q.rresp;
   assign fs_ls_driver_enable_n    = st_q.fs_oe_n;                           // R1
   assign fs_ls_dp_out             = st_q.fs_pos;                            // R2
   assign fs_ls_dm_out             = st_q.fs_neg;                            // R3
   assign frontend_hs_tx_valid_bus = st_q.txv_out;
   assign hs_tx_serial             = st_q.ser_bit;
   assign hs_current_source_on     = st_q.cs_out;
   assign hs_drive_current_sel     = st_q.boost;                             // R8
   assign dp_pullup_on             = st_q.rpu_dp;                            // R12
   assign dm_pullup_on             = st_q.rpu_dm;                            // R13
   assign dp_pulldown_on           = st_q.rpd_dp;                            // R14
   assign dm_pulldown_on           = st_q.rpd_dm;                            // R15
   assign hs_driver_active         = st_q.active;                            // R16

endmodule // uat_test_override

/* verification/test_usb2_afe_test_override_reg.sv */
// Purpose: self-checking bench for the front-end test override register
// Assumes: axi4-lite master driven at rising edges
// Notes:   bready and rready are offered with each request, dropped at the answer
`timescale 1ns/1ps
module test_usb2_afe_test_override_reg
   import uat_pkg::*;
;
   logic        aclk = 1'h0, aresetn = 1'h0, hs_mode = 1'h0, fs_ls_diff_rx_out = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, nv_drive_current_default = 3'h5;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, frontend_hs_tx_valid_bus, rsp;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, usb_reset = 1'h0, lite_reset = 1'h0;
   logic        eeprom_present = 1'h0, otp_programmed = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, fs_ls_driver_enable_n, fs_ls_dp_out;
   logic        fs_ls_dm_out, hs_tx_serial, hs_current_source_on, dp_pullup_on, dm_pullup_on;
   logic        dp_pulldown_on, dm_pulldown_on, hs_driver_active;
   logic [2:0]  hs_drive_current_sel;
   int          n_errors = 0, checks = 0;
   wire  [13:0] outs = {fs_ls_driver_enable_n, fs_ls_dp_out, fs_ls_dm_out,
      frontend_hs_tx_valid_bus, hs_current_source_on, hs_drive_current_sel, dp_pullup_on,
      dm_pullup_on, dp_pulldown_on, dm_pulldown_on, hs_driver_active};

   always #2 aclk = ~aclk;

   uat_test_override u_uat_test_override (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fs_ls_diff_rx_out,
      .hs_mode, .usb_reset, .lite_reset, .eeprom_present, .otp_programmed,
      .nv_drive_current_default, .fs_ls_driver_enable_n, .fs_ls_dp_out, .fs_ls_dm_out,
      .frontend_hs_tx_valid_bus, .hs_tx_serial, .hs_current_source_on, .hs_drive_current_sel,
      .dp_pullup_on, .dm_pullup_on, .dp_pulldown_on, .dm_pulldown_on, .hs_driver_active);
////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (n_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 50) begin
         n_errors++;
         $display("ERROR %0t ns: no bus answer", $time);
         stop_test();
      end
   endtask

   // bready stands from the request on and drops at the edge that shows bvalid
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         tick(n);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         rsp = s_axi_bresp;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask

   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         tick(n);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         rd_q = s_axi_rdata;
         rsp  = s_axi_rresp;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask

   task automatic boot(input logic e, input logic o);
      eeprom_present <= e;
      otp_programmed <= o;
      aresetn        <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
   endtask

   task automatic pulse(input logic l);
      @(posedge aclk);
      lite_reset <= l;
      usb_reset  <= ~l;
      @(posedge aclk);
      lite_reset <= 1'h0;
      usb_reset  <= 1'h0;
      @(posedge aclk);
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic s_boot();
      for (int i = 0; i < 3; i++) begin
         boot(i == 0, i == 1);
         rd(UAT_OFF_TEST);
         chk(rd_q, (i < 2) ? 32'h0000_0500 : 32'h0);
      end
   endtask

   task automatic s_fields();
      logic [31:0] p[2];
      logic [31:0] v;
      logic        s0, s1;
      p = '{32'hffff_ffff, 32'hffa7_63ad};
      fs_ls_diff_rx_out <= 1'h1;
      for (int i = 0; i < 2; i++) begin
         v = p[i];
         wr(UAT_OFF_TEST, v, 4'hf);
         // the write lands as bvalid rises, so lsb then msb show on the next two edges
         @(posedge aclk);
         s0 = hs_tx_serial;
         @(posedge aclk);
         s1 = hs_tx_serial;
         chk({s1, s0}, v[13:12]);
         rd(UAT_OFF_TEST);
         chk(rd_q, (v & 32'h0070_fff2) | 32'h0008_0000);
         chk(outs, {v[22:20], v[15:14], v[11:4], v[1]});
      end
      wr(UAT_OFF_TEST, 32'h0, 4'h1);
      fs_ls_diff_rx_out <= 1'h0;
      rd(UAT_OFF_TEST);
      chk(rd_q, 32'h0020_6300);
   endtask

   task automatic s_refuse();
      wr(UAT_OFF_TEST, 32'h0000_bf00, 4'h2);
      chk(rsp, UAT_RESP_SLVERR);
      wr(12'h0c8, 32'hffff_ffff, 4'hf);
      chk(rsp, UAT_RESP_DECERR);
      rd(12'h0c8);
      chk(rsp, UAT_RESP_DECERR);
      chk(rd_q, 32'h0);
      rd(UAT_OFF_TEST);
      chk(rd_q, 32'h0020_6300);
   endtask

   task automatic s_hs();
      hs_mode <= 1'h1;
      rd(UAT_OFF_TEST);
      chk({hs_current_source_on, rd_q[11]}, 2'h3);
      hs_mode <= 1'h0;
      for (int i = 0; i < 8; i++) begin
         wr(UAT_OFF_TEST, 32'(i) << 8, 4'h2);
         chk(hs_drive_current_sel, 32'(i));
      end
   endtask

   // live default moves after boot, so only the boot image may come back
   task automatic s_reload();
      boot(1'h1, 1'h0);
      nv_drive_current_default <= 3'h6;
      for (int i = 0; i < 2; i++) begin
         wr(UAT_OFF_TEST, 32'h0000_0100, 4'h2);
         pulse(i == 1);
         chk(hs_drive_current_sel, 32'h5);
      end
      eeprom_present <= 1'h0;
      otp_programmed <= 1'h1;
      pulse(1'h1);
      chk(hs_drive_current_sel, 32'h0);
   endtask

   initial begin
      s_boot();
      s_fields();
      s_refuse();
      s_hs();
      s_reload();
      stop_test();
   end
endmodule // test_usb2_afe_test_override_reg

bind uat_test_override uat_test_override_asserts u_uat_test_override_asserts (.aclk, .aresetn,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .hs_mode, .usb_reset, .lite_reset, .eeprom_present,
   .hs_current_source_on, .hs_drive_current_sel, .frontend_hs_tx_valid_bus);

/* verification/uat_test_override_asserts.sv */
// Purpose: port-level property checks for the front-end test override register
// Assumes: one clock, aresetn synchronous and active low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module uat_test_override_asserts
   import uat_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        hs_mode,
   input wire logic        usb_reset,
   input wire logic        lite_reset,
   input wire logic        eeprom_present,
   input wire logic        hs_current_source_on,
   input wire logic [2:0]  hs_drive_current_sel,
   input wire logic [1:0]  frontend_hs_tx_valid_bus
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
   a_cs_forced: assert property (hs_mode |=> hs_current_source_on)
      else $error("current source off in high-speed mode");
   a_mask_legal: assert property (frontend_hs_tx_valid_bus != UAT_TXV_BAD)
      else $error("illegal valid mask on front end");
   a_refused_keep: assert property ($rose(s_axi_bvalid) && s_axi_bresp == UAT_RESP_SLVERR
      |-> $stable(frontend_hs_tx_valid_bus) && $stable(hs_drive_current_sel))
      else $error("refused write changed outputs");
   a_boost_clear: assert property ((usb_reset || lite_reset) && !eeprom_present
      |=> hs_drive_current_sel == UAT_BOOST_RST)
      else $error("boost not cleared without eeprom");
   a_rsv_zero: assert property ($rose(s_axi_rvalid) |-> (s_axi_rdata & 32'hff87_000d) == 0)
      else $error("reserved bits read nonzero");
   a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == UAT_RESP_DECERR
      |-> s_axi_rdata == 32'h0)
      else $error("unmapped read returned data");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
endmodule // uat_test_override_asserts
